// [common/core_ctrl_defines.vh]
// constants for the stack and interrupt control block
`ifndef CORE_CTRL_DEFINES_VH
`define CORE_CTRL_DEFINES_VH
// io space offsets
`define IO_STACK_LOW     6'h10
`define IO_STACK_HIGH    6'h11
`define IO_PAGE_SELECT   6'h12
// reset values
`define SP_RESET         16'h0000
`define PAGE_RESET       1'b0
// data space
`define REGFILE_SIZE     16'h0020
// pointer pair bases
`define PTR_X_BASE       5'h1a
`define PTR_Y_BASE       5'h1c
`define PTR_Z_BASE       5'h1e
// pointer modes
`define PTR_PLAIN        2'h0
`define PTR_DISP         2'h1
`define PTR_POSTINC      2'h2
`define PTR_PREDEC       2'h3
// interrupt sources and vectors
`define NUM_IRQ          8
`define IRQ_IDX_W        3
`define VEC_STRIDE       16'h0002
`define RESET_VECTOR     16'h0000
// timing in clock cycles
`define ENTRY_CYCLES     4'h4
`define SLEEP_EXTRA      4'h4
`define RETURN_CYCLES    4'h4
`endif

// [core/cpu_stack_and_interrupt_control.v]
// stack pointer, pointer registers, page select and interrupt sequencing
// Overview of operation
// - register file offers 8/8, 8+8/8, 8+8/16 and 16/16 read and write-back
// - the 32 working registers also sit at data addresses 0 to 31
// - registers 26 to 31 form three 16-bit pointers with displacement, increment, decrement
// - stack grows downward; pointer marks top; a byte push lowers it by one
// - a byte pop raises the stack pointer by one and reads at the raised address
// - calls and interrupt entry lower it by two; returns raise it by two
// - stack pointer lives in two 8-bit io registers, cleared at reset
// - page select bits 7 to 1 read zero; software writes them zero
// - page bit picks lower or upper 64K half for extended load and store
// - ordinary program loads ignore the page bit
// - core runs undivided; two-register operation writes back in one cycle
// - a source is taken only with its enable and global enable set
// - interrupts are blocked by programmed lock bits depending on program counter
// - vectors at lowest addresses; lower vector means higher priority, reset first
// - vector select moves interrupt vectors, boot fuse moves reset vector, to boot start
// - entry clears global enable; return sets it; handler may set it to nest
// - flag is cleared when vectored, or when software writes one to it
// - disabled flags stay pending until enabled or cleared, then served by priority
// - level sources request only while their condition holds
// - after return one main instruction runs before another interrupt
// - global disable acts at once, same cycle too; status is never saved
// - entry takes four cycles pushing the program counter, eight from sleep
// - return takes four cycles, pops two bytes, raises pointer by two, sets enable
// - after global enable the next instruction completes before any interrupt
`timescale 1ns/1ps
`include "core_ctrl_defines.vh"
module cpu_stack_and_interrupt_control (
   clk_sys,
   rst,
   rf_rd_a_addr,
   rf_rd_b_addr,
   rf_wr_en,
   rf_wr_wide,
   rf_wr_addr,
   rf_wr_data,
   rf_rd_a_data,
   rf_rd_b_data,
   rf_rd_w_data,
   ds_addr,
   ds_wr,
   ds_wdata,
   ds_hit,
   ds_rdata,
   ptr_req,
   ptr_sel,
   ptr_mode,
   ptr_disp,
   ptr_addr,
   pm_req,
   pm_ext,
   pm_addr,
   io_addr,
   io_wr,
   io_wdata,
   io_rdata,
   sp_push1,
   sp_pop1,
   sp_push2,
   sp_pop2,
   stack_pointer,
   stk_addr,
   stk_wr,
   stk_wdata,
   stk_rd,
   stk_rdata,
   irq_event,
   irq_level,
   irq_en,
   flag_clr_wr,
   flag_clr_data,
   irq_flags,
   instr_done,
   sleeping,
   pc_now,
   exec_sei,
   exec_cli,
   exec_return_from_interrupt,
   status_register_wr,
   status_register_wdata,
   global_enable,
   app_lock_bit,
   boot_lock_bit,
   vector_select_bit,
   boot_reset_fuse,
   boot_start,
   reset_vector,
   irq_busy,
   vec_valid,
   vec_addr,
   pc_restore_valid,
   pc_restore
);
   input  wire                  clk_sys;
   input  wire                  rst;
   input  wire [4:0]            rf_rd_a_addr;
   input  wire [4:0]            rf_rd_b_addr;
   input  wire                  rf_wr_en;
   input  wire                  rf_wr_wide;
   input  wire [4:0]            rf_wr_addr;
   input  wire [15:0]           rf_wr_data;
   output wire [7:0]            rf_rd_a_data;
   output wire [7:0]            rf_rd_b_data;
   output wire [15:0]           rf_rd_w_data;
   input  wire [15:0]           ds_addr;
   input  wire                  ds_wr;
   input  wire [7:0]            ds_wdata;
   output wire                  ds_hit;
   output reg  [7:0]            ds_rdata;
   input  wire                  ptr_req;
   input  wire [1:0]            ptr_sel;
   input  wire [1:0]            ptr_mode;
   input  wire [5:0]            ptr_disp;
   output reg  [15:0]           ptr_addr;
   input  wire                  pm_req;
   input  wire                  pm_ext;
   output reg  [16:0]           pm_addr;
   input  wire [5:0]            io_addr;
   input  wire                  io_wr;
   input  wire [7:0]            io_wdata;
   output reg  [7:0]            io_rdata;
   input  wire                  sp_push1;
   input  wire                  sp_pop1;
   input  wire                  sp_push2;
   input  wire                  sp_pop2;
   output wire [15:0]           stack_pointer;
   output reg  [15:0]           stk_addr;
   output reg                   stk_wr;
   output reg  [7:0]            stk_wdata;
   output reg                   stk_rd;
   input  wire [7:0]            stk_rdata;
   input  wire [`NUM_IRQ-1:0]   irq_event;
   input  wire [`NUM_IRQ-1:0]   irq_level;
   input  wire [`NUM_IRQ-1:0]   irq_en;
   input  wire                  flag_clr_wr;
   input  wire [`NUM_IRQ-1:0]   flag_clr_data;
   output wire [`NUM_IRQ-1:0]   irq_flags;
   input  wire                  instr_done;
   input  wire                  sleeping;
   input  wire [15:0]           pc_now;
   input  wire                  exec_sei;
   input  wire                  exec_cli;
   input  wire                  exec_return_from_interrupt;
   input  wire                  status_register_wr;
   input  wire [7:0]            status_register_wdata;
   output wire                  global_enable;
   input  wire                  app_lock_bit;
   input  wire                  boot_lock_bit;
   input  wire                  vector_select_bit;
   input  wire                  boot_reset_fuse;
   input  wire [15:0]           boot_start;
   output reg  [15:0]           reset_vector;
   output wire                  irq_busy;
   output reg                   vec_valid;
   output reg  [15:0]           vec_addr;
   output reg                   pc_restore_valid;
   output reg  [15:0]           pc_restore;

   localparam [1:0] ST_IDLE   = 2'd0;
   localparam [1:0] ST_ENTRY  = 2'd1;
   localparam [1:0] ST_RETURN = 2'd2;

   reg  [1:0]             state_ff;
   reg  [1:0]             nxt_state;
   reg  [3:0]             cnt_ff;
   reg  [3:0]             entry_len_ff;
   reg  [15:0]            sp_ff;
   reg  [15:0]            nxt_sp;
   reg                    page_ff;
   reg                    gie_ff;
   reg                    nxt_gie;
   reg  [`NUM_IRQ-1:0]    flag_ff;
   reg  [15:0]            pc_save_ff;
   reg  [7:0]             ret_high_ff;
   reg  [`IRQ_IDX_W-1:0]  win_idx;
   reg                    win_any;
   reg  [`NUM_IRQ-1:0]    win_onehot;
   reg  [15:0]            ptr_base;
   reg  [4:0]             ptr_pair;
   reg                    ptr_upd;
   reg  [15:0]            ptr_new;
   reg                    wr_en;
   reg                    wr_wide;
   reg  [4:0]             wr_addr;
   reg  [15:0]            wr_data;
   wire [`NUM_IRQ-1:0]    req;
   wire                   lock_block;
   wire                   cli_now;
   wire                   take;
   wire                   ret_done;
   wire [15:0]            ptr_x;
   wire [15:0]            ptr_y;
   wire [15:0]            ptr_z;
   wire [7:0]             ds_reg_data;
   wire [15:0]            vec_base;
   integer                k;

   gp_register_file u_regs (
      .clk_sys   (clk_sys),
      .rst       (rst),
      .rd_a_addr (rf_rd_a_addr),
      .rd_b_addr (rf_rd_b_addr),
      .rd_c_addr (ds_addr[4:0]),
      .wr_en     (wr_en),
      .wr_wide   (wr_wide),
      .wr_addr   (wr_addr),
      .wr_data   (wr_data),
      .rd_a_data (rf_rd_a_data),
      .rd_b_data (rf_rd_b_data),
      .rd_c_data (ds_reg_data),
      .rd_w_data (rf_rd_w_data),
      .ptr_x     (ptr_x),
      .ptr_y     (ptr_y),
      .ptr_z     (ptr_z)
   );

   // pointer address and update
   always @*
   begin
      ptr_base = ptr_x;
      ptr_pair = `PTR_X_BASE;
      if (ptr_sel == 2'd1)
      begin
         ptr_base = ptr_y;
         ptr_pair = `PTR_Y_BASE;
      end
      else if (ptr_sel == 2'd2)
      begin
         ptr_base = ptr_z;
         ptr_pair = `PTR_Z_BASE;
      end
      ptr_addr = ptr_base;
      ptr_new  = ptr_base;
      ptr_upd  = 1'b0;
      case (ptr_mode)
         `PTR_DISP:    ptr_addr = ptr_base + {10'h000, ptr_disp};
         `PTR_POSTINC:
         begin
            ptr_new = ptr_base + 16'h0001;
            ptr_upd = ptr_req;
         end
         `PTR_PREDEC:
         begin
            ptr_new  = ptr_base - 16'h0001;
            ptr_addr = ptr_new;
            ptr_upd  = ptr_req;
         end
         default:      ptr_addr = ptr_base;
      endcase
   end

   // write port: execution, then pointer update, then data space
   assign ds_hit = (ds_addr < `REGFILE_SIZE);

   always @*
   begin
      wr_en   = 1'b0;
      wr_wide = 1'b0;
      wr_addr = rf_wr_addr;
      wr_data = rf_wr_data;
      if (rf_wr_en)
      begin
         wr_en   = 1'b1;
         wr_wide = rf_wr_wide;
      end
      else if (ptr_upd)
      begin
         wr_en   = 1'b1;
         wr_wide = 1'b1;
         wr_addr = ptr_pair;
         wr_data = ptr_new;
      end
      else if (ds_wr && ds_hit)
      begin
         wr_en   = 1'b1;
         wr_addr = ds_addr[4:0];
         wr_data = {8'h00, ds_wdata};
      end
   end

   always @(posedge clk_sys)
   begin
      if (rst)
         ds_rdata <= 8'h00;
      else
         ds_rdata <= ds_hit ? ds_reg_data : 8'h00;
   end

   // program memory byte address
   always @*
   begin
      pm_addr = {1'b0, ptr_z};
      if (pm_req && pm_ext)
         pm_addr = {page_ff, ptr_z};
   end

   // io registers
   always @(posedge clk_sys)
   begin
      if (rst)
      begin
         page_ff  <= `PAGE_RESET;
         io_rdata <= 8'h00;
      end
      else
      begin
         if (io_wr && (io_addr == `IO_PAGE_SELECT))
            page_ff <= io_wdata[0];
         if (io_addr == `IO_STACK_LOW)
            io_rdata <= sp_ff[7:0];
         else if (io_addr == `IO_STACK_HIGH)
            io_rdata <= sp_ff[15:8];
         else if (io_addr == `IO_PAGE_SELECT)
            io_rdata <= {7'h00, page_ff};
         else
            io_rdata <= 8'h00;
      end
   end

   // stack pointer
   always @*
   begin
      nxt_sp = sp_ff;
      if (io_wr && (io_addr == `IO_STACK_LOW))
         nxt_sp[7:0] = io_wdata;
      if (io_wr && (io_addr == `IO_STACK_HIGH))
         nxt_sp[15:8] = io_wdata;
      if (state_ff == ST_ENTRY)
      begin
         if (cnt_ff == 4'h1)
            nxt_sp = sp_ff - 16'h0002;
      end
      else if (state_ff == ST_RETURN)
      begin
         if (ret_done)
            nxt_sp = sp_ff + 16'h0002;
      end
      else if (sp_push1)
         nxt_sp = sp_ff - 16'h0001;
      else if (sp_pop1)
         nxt_sp = sp_ff + 16'h0001;
      else if (sp_push2)
         nxt_sp = sp_ff - 16'h0002;
      else if (sp_pop2)
         nxt_sp = sp_ff + 16'h0002;
   end

   always @(posedge clk_sys)
   begin
      if (rst)
         sp_ff <= `SP_RESET;
      else
         sp_ff <= nxt_sp;
   end

   assign stack_pointer = sp_ff;

   // stack memory port
   always @*
   begin
      stk_addr  = (sp_pop1 || sp_pop2) ? sp_ff + 16'h0001 : sp_ff;
      stk_wr    = 1'b0;
      stk_rd    = 1'b0;
      stk_wdata = 8'h00;
      if (state_ff == ST_ENTRY)
      begin
         if (cnt_ff == 4'h0)
         begin
            stk_wr    = 1'b1;
            stk_wdata = pc_save_ff[7:0];
         end
         else if (cnt_ff == 4'h1)
         begin
            stk_wr    = 1'b1;
            stk_addr  = sp_ff - 16'h0001;
            stk_wdata = pc_save_ff[15:8];
         end
      end
      else if (state_ff == ST_RETURN)
      begin
         if (cnt_ff == 4'h0)
         begin
            stk_rd   = 1'b1;
            stk_addr = sp_ff + 16'h0001;
         end
         else if (cnt_ff == 4'h1)
         begin
            stk_rd   = 1'b1;
            stk_addr = sp_ff + 16'h0002;
         end
      end
   end

   // interrupt request arbitration
   assign req        = (flag_ff | irq_level) & irq_en;
   assign lock_block = (app_lock_bit && (pc_now < boot_start)) ||
                       (boot_lock_bit && (pc_now >= boot_start));
   assign cli_now    = exec_cli || (status_register_wr && !status_register_wdata[7]);

   always @*
   begin
      win_idx    = {`IRQ_IDX_W{1'b0}};
      win_any    = 1'b0;
      win_onehot = {`NUM_IRQ{1'b0}};
      for (k = `NUM_IRQ - 1; k >= 0; k = k - 1)
      begin
         if (req[k])
         begin
            win_idx = k[`IRQ_IDX_W-1:0];
            win_any = 1'b1;
         end
      end
      if (win_any)
         win_onehot[win_idx] = 1'b1;
   end

   // taken only when idle at a boundary, so one instruction follows a return
   assign take = (state_ff == ST_IDLE) && (instr_done || sleeping) &&
                 gie_ff && !cli_now && !lock_block && !exec_return_from_interrupt && win_any;
   assign ret_done = (state_ff == ST_RETURN) && (cnt_ff == `RETURN_CYCLES - 4'h1);
   assign irq_busy = (state_ff != ST_IDLE);

   // pending flags, set wins over clear
   always @(posedge clk_sys)
   begin
      if (rst)
         flag_ff <= {`NUM_IRQ{1'b0}};
      else
         flag_ff <= (flag_ff & ~(take ? win_onehot : {`NUM_IRQ{1'b0}}) &
                     ~(flag_clr_wr ? flag_clr_data : {`NUM_IRQ{1'b0}})) |
                    irq_event;
   end

   assign irq_flags = flag_ff;

   // global enable, registered so a set acts after the next instruction
   always @*
   begin
      nxt_gie = gie_ff;
      if (status_register_wr)
         nxt_gie = status_register_wdata[7];
      if (exec_sei)
         nxt_gie = 1'b1;
      if (cli_now)
         nxt_gie = 1'b0;
      if (ret_done)
         nxt_gie = 1'b1;
      if (take)
         nxt_gie = 1'b0;
   end

   always @(posedge clk_sys)
   begin
      if (rst)
         gie_ff <= 1'b0;
      else
         gie_ff <= nxt_gie;
   end

   assign global_enable = gie_ff;

   // entry and return sequencer
   always @*
   begin
      nxt_state = state_ff;
      case (state_ff)
         ST_IDLE:
         begin
            if (take)
               nxt_state = ST_ENTRY;
            else if (exec_return_from_interrupt)
               nxt_state = ST_RETURN;
         end
         ST_ENTRY:
         begin
            if (cnt_ff == entry_len_ff - 4'h1)
               nxt_state = ST_IDLE;
         end
         ST_RETURN:
         begin
            if (ret_done)
               nxt_state = ST_IDLE;
         end
         default:   nxt_state = ST_IDLE;
      endcase
   end

   assign vec_base = vector_select_bit ? boot_start : 16'h0000;

   always @(posedge clk_sys)
   begin
      if (rst)
      begin
         state_ff         <= ST_IDLE;
         cnt_ff           <= 4'h0;
         entry_len_ff     <= `ENTRY_CYCLES;
         pc_save_ff       <= 16'h0000;
         ret_high_ff      <= 8'h00;
         vec_valid        <= 1'b0;
         vec_addr         <= 16'h0000;
         pc_restore_valid <= 1'b0;
         pc_restore       <= 16'h0000;
         reset_vector     <= `RESET_VECTOR;
      end
      else
      begin
         state_ff         <= nxt_state;
         vec_valid        <= 1'b0;
         pc_restore_valid <= 1'b0;
         reset_vector     <= boot_reset_fuse ? boot_start : `RESET_VECTOR;
         if (state_ff == ST_IDLE)
         begin
            cnt_ff <= 4'h0;
            if (take)
            begin
               pc_save_ff   <= pc_now;
               entry_len_ff <= sleeping ? `ENTRY_CYCLES + `SLEEP_EXTRA : `ENTRY_CYCLES;
               vec_addr     <= vec_base + `VEC_STRIDE * ({13'h0000, win_idx} + 16'h0001);
            end
         end
         else
         begin
            cnt_ff <= cnt_ff + 4'h1;
            if ((state_ff == ST_ENTRY) && (cnt_ff == entry_len_ff - 4'h1))
               vec_valid <= 1'b1;
            if ((state_ff == ST_RETURN) && (cnt_ff == 4'h1))
               ret_high_ff <= stk_rdata;
            if (ret_done)
            begin
               pc_restore       <= {ret_high_ff, stk_rdata};
               pc_restore_valid <= 1'b1;
            end
         end
      end
   end
endmodule

// [core/gp_register_file.v]
// working register file with pointer and data space views
`timescale 1ns/1ps
module gp_register_file (
   clk_sys,
   rst,
   rd_a_addr,
   rd_b_addr,
   rd_c_addr,
   wr_en,
   wr_wide,
   wr_addr,
   wr_data,
   rd_a_data,
   rd_b_data,
   rd_c_data,
   rd_w_data,
   ptr_x,
   ptr_y,
   ptr_z
);
   input  wire        clk_sys;
   input  wire        rst;
   input  wire [4:0]  rd_a_addr;
   input  wire [4:0]  rd_b_addr;
   input  wire [4:0]  rd_c_addr;
   input  wire        wr_en;
   input  wire        wr_wide;
   input  wire [4:0]  wr_addr;
   input  wire [15:0] wr_data;
   output wire [7:0]  rd_a_data;
   output wire [7:0]  rd_b_data;
   output wire [7:0]  rd_c_data;
   output wire [15:0] rd_w_data;
   output wire [15:0] ptr_x;
   output wire [15:0] ptr_y;
   output wire [15:0] ptr_z;

   reg [7:0] regs_ff [0:31];

   genvar i;
   generate
      for (i = 0; i < 32; i = i + 1)
      begin : g_reg
         localparam [4:0] IDX = i;
         always @(posedge clk_sys)
         begin
            if (rst)
               regs_ff[i] <= 8'h00;
            else if (wr_en && wr_wide && (wr_addr[4:1] == IDX[4:1]))
               regs_ff[i] <= IDX[0] ? wr_data[15:8] : wr_data[7:0];
            else if (wr_en && !wr_wide && (wr_addr == IDX))
               regs_ff[i] <= wr_data[7:0];
         end
      end
   endgenerate

   // 8-bit operands, one 16-bit pair operand
   assign rd_a_data = regs_ff[rd_a_addr];
   assign rd_b_data = regs_ff[rd_b_addr];
   assign rd_c_data = regs_ff[rd_c_addr];
   assign rd_w_data = {regs_ff[{rd_a_addr[4:1], 1'b1}], regs_ff[{rd_a_addr[4:1], 1'b0}]};
   assign ptr_x     = {regs_ff[27], regs_ff[26]};
   assign ptr_y     = {regs_ff[29], regs_ff[28]};
   assign ptr_z     = {regs_ff[31], regs_ff[30]};
endmodule

// [testbench/cpu_stack_chk.sv]
// port checker for stack and interrupt control
`timescale 1ns/1ps
`include "core_ctrl_defines.vh"
module cpu_stack_chk (
   input wire        clk_sys,
   input wire        rst,
   input wire        sp_push1,
   input wire        sp_pop1,
   input wire        sp_push2,
   input wire        sp_pop2,
   input wire [15:0] stack_pointer,
   input wire [5:0]  io_addr,
   input wire [7:0]  io_rdata,
   input wire [15:0] ds_addr,
   input wire        ds_hit,
   input wire        stk_wr,
   input wire        stk_rd,
   input wire        irq_busy,
   input wire        global_enable,
   input wire        vec_valid,
   input wire        pc_restore_valid,
   input wire        exec_cli,
   input wire        sleeping
);
   default clocking @(posedge clk_sys);
   endclocking
   default disable iff (rst);
   sequence entry_s;
      !irq_busy && !sleeping ##1 irq_busy && stk_wr;
   endsequence
   chk_push_one: assert property (sp_push1 && !irq_busy
      |=> stack_pointer == $past(stack_pointer) - 16'h0001) else $error("push step wrong");
   chk_pop_one: assert property (sp_pop1 && !sp_push1 && !irq_busy
      |=> stack_pointer == $past(stack_pointer) + 16'h0001) else $error("pop step wrong");
   chk_pop_two: assert property (sp_pop2 && !(sp_push1 | sp_pop1 | sp_push2) && !irq_busy
      |=> stack_pointer == $past(stack_pointer) + 16'h0002) else $error("double pop wrong");
   chk_page_zero: assert property (io_addr == `IO_PAGE_SELECT
      |=> io_rdata[7:1] == 7'h00) else $error("page upper bits set");
   chk_reg_window: assert property (ds_hit == (ds_addr[15:5] == 11'h000))
      else $error("data hit wrong");
   chk_entry_gie: assert property (entry_s
      |-> !global_enable && $past(global_enable)) else $error("entry enable wrong");
   chk_entry_len: assert property (entry_s
      |-> irq_busy[*4] ##1 !irq_busy && vec_valid) else $error("entry length wrong");
   chk_sleep_len: assert property (sleeping && !irq_busy ##1 irq_busy && stk_wr
      |-> irq_busy[*8] ##1 !irq_busy && vec_valid) else $error("sleep entry length wrong");
   chk_return_len: assert property (!irq_busy ##1 irq_busy && stk_rd
      |-> ##4 pc_restore_valid && global_enable && stack_pointer == $past(stack_pointer, 4) + 16'h0002)
      else $error("return wrong");
   chk_cli_block: assert property (exec_cli && !irq_busy
      |=> !global_enable && !irq_busy) else $error("entry after disable");
   cover property (entry_s);
   cover property (pc_restore_valid);
   cover property (exec_cli && !irq_busy);
   cover property (sleeping && !irq_busy ##1 irq_busy && stk_wr);
endmodule
bind cpu_stack_and_interrupt_control cpu_stack_chk chk_i (.*);

// [testbench/stack_mem_model.sv]
// stack memory on the far side of the stack port
`timescale 1ns/1ps
module stack_mem_model (
   input wire        clk_sys,
   input wire [15:0] stk_addr,
   input wire        stk_wr,
   input wire [7:0]  stk_wdata,
   input wire        stk_rd,
   output reg [7:0]  stk_rdata
);
   reg [7:0] mem [0:65535];
   initial stk_rdata = 8'h00;
   always @(posedge clk_sys)
   begin
      if (stk_wr)
         mem[stk_addr] <= stk_wdata;
      if (stk_rd)
         stk_rdata <= mem[stk_addr];
   end
endmodule

// [testbench/test_cpu_stack_and_interrupt_control.sv]
// self-checking bench for stack and interrupt control
`timescale 1ns/1ps
`include "core_ctrl_defines.vh"
module test_cpu_stack_and_interrupt_control;
   logic clk_sys=0, rst=1, rf_wr_en=0, rf_wr_wide=0, ds_wr=0, ptr_req=0, pm_req=0, pm_ext=0;
   logic io_wr=0, sp_push1=0, sp_pop1=0, sp_push2=0, sp_pop2=0, flag_clr_wr=0, instr_done=0;
   logic sleeping=0, exec_sei=0, exec_cli=0, exec_return_from_interrupt=0, status_register_wr=0, app_lock_bit=0, boot_lock_bit=0;
   logic vector_select_bit=0, boot_reset_fuse=0;
   logic [4:0]  rf_rd_a_addr=0, rf_rd_b_addr=0, rf_wr_addr=0;
   logic [1:0]  ptr_sel=0, ptr_mode=0;
   logic [5:0]  ptr_disp=0, io_addr=0;
   logic [7:0]  ds_wdata=0, io_wdata=0, flag_clr_data=0, status_register_wdata=0, irq_event=0, irq_level=0, irq_en=0;
   logic [15:0] rf_wr_data=0, ds_addr=0, pc_now=0, boot_start=0, v;
   wire [7:0]   rf_rd_a_data, rf_rd_b_data, ds_rdata, io_rdata, stk_wdata, stk_rdata, irq_flags;
   wire [15:0]  rf_rd_w_data, ptr_addr, stack_pointer, stk_addr, reset_vector, vec_addr, pc_restore;
   wire [16:0]  pm_addr;
   wire         ds_hit, stk_wr, stk_rd, global_enable, irq_busy, vec_valid, pc_restore_valid;
   integer      err_count=0, n_tests=0, seed=32'h673a, i;
   logic [15:0] q[$];
   cpu_stack_and_interrupt_control dut (.*);
   stack_mem_model mem_i (.*);
   always #5 clk_sys = ~clk_sys;
   task chk(input [16:0] e, s, input string n);
      n_tests++;
      if (s !== e)
      begin
         err_count++;
         $display("unexpected %s expected %h seen %h", n, e, s);
      end
   endtask
   task test_done;
      if (err_count == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // one edge samples the pulses, then they drop
   task go;
      @(posedge clk_sys);
      {rf_wr_en, ds_wr, ptr_req, io_wr, sp_push1, sp_pop1, sp_push2, sp_pop2, flag_clr_wr,
         instr_done, exec_sei, exec_cli, exec_return_from_interrupt, status_register_wr, irq_event} <= '0;
      #1;
   endtask
   task iow(input [5:0] a, input [7:0] d);
      io_addr <= a;
      io_wdata <= d;
      io_wr <= 1;
      go;
   endtask
   task take;
      instr_done <= 1;
      repeat (6) go;
      chk(0, global_enable, "enable after entry");
   endtask
   task ret;
      q.push_back(pc_now);
      exec_return_from_interrupt <= 1;
      repeat (6) go;
      chk(1, global_enable, "enable after return");
      chk(16'h0100, stack_pointer, "stack after return");
   endtask
   always @(posedge clk_sys)
      if ((vec_valid | pc_restore_valid) === 1'b1)
         chk(q.size() ? q.pop_front() : 'x, vec_valid ? vec_addr : pc_restore, "vector or pc");
   initial
   begin
      #50000;
      err_count++;
      test_done;
   end
   initial
   begin
      repeat (10) @(posedge clk_sys);
      rst <= 0;
      go;
      for (i = 0; i < 4; i++)
      begin
         io_addr <= 6'(`IO_STACK_LOW + i);
         go;
         chk(0, io_rdata, "io reset");
      end
      v = 16'($random(seed));
      iow(`IO_STACK_LOW, v[7:0]);
      iow(`IO_STACK_HIGH, v[15:8]);
      chk(v, stack_pointer, "stack pointer");
      go;
      chk(v[15:8], io_rdata, "pointer high");
      iow(`IO_PAGE_SELECT, 8'hff);
      go;
      chk(1, io_rdata, "page select");
      iow(6'h13, 8'hff);
      go;
      chk(0, io_rdata, "unmapped");
      pm_req <= 1;
      pm_ext <= 1;
      go;
      chk(17'h1_0000, pm_addr, "extended load");
      pm_ext <= 0;
      go;
      chk(0, pm_addr, "plain load");
      for (i = 0; i < 4; i++)
      begin
         {sp_pop2, sp_push2, sp_pop1, sp_push1} <= 4'(1 << i);
         v += 16'(i == 0 ? -1 : i == 1 ? 1 : i == 2 ? -2 : 2);
         go;
         chk(v, stack_pointer, "stack op");
      end
      v = 16'($random(seed));
      rf_wr_en <= 1;
      rf_wr_wide <= 1;
      rf_wr_addr <= `PTR_X_BASE;
      rf_wr_data <= v;
      rf_rd_a_addr <= `PTR_X_BASE;
      ds_addr <= 16'h001b;
      go;
      chk(v, rf_rd_w_data, "wide write");
      chk(v[7:0], rf_rd_a_data, "operand a");
      go;
      chk(v[15:8], ds_rdata, "register as data");
      ptr_mode <= `PTR_POSTINC;
      ptr_req <= 1;
      go;
      chk(16'(v + 16'h0001), rf_rd_w_data, "increment");
      ptr_mode <= `PTR_DISP;
      ptr_disp <= 6'h3f;
      go;
      chk(16'(v + 16'h0040), ptr_addr, "displacement");
      ptr_sel <= 2'd2;
      ptr_mode <= `PTR_PREDEC;
      ptr_req <= 1;
      go;
      chk(17'h0_ffff, pm_addr, "decrement");
      ds_addr <= 16'h0003;
      ds_wr <= 1;
      ds_wdata <= v[7:0];
      rf_rd_b_addr <= 5'h03;
      go;
      chk(v[7:0], rf_rd_b_data, "data to register");
      ds_addr <= `REGFILE_SIZE;
      go;
      chk(0, ds_hit, "beyond registers");
      iow(`IO_STACK_LOW, 8'h00);
      iow(`IO_STACK_HIGH, 8'h01);
      pc_now <= {5'h00, v[10:0]};
      irq_en <= 8'h26;
      irq_event <= 8'h24;
      instr_done <= 1;
      go;
      go;
      chk(8'h24, irq_flags, "pending flags");
      exec_sei <= 1;
      instr_done <= 1;
      go;
      go;
      chk(0, irq_busy, "entry after enable");
      q.push_back(16'h0006);
      take;
      chk(8'h20, irq_flags, "flag after entry");
      chk(16'h00fe, stack_pointer, "entry stack");
      ret;
      vector_select_bit <= 1;
      boot_start <= 16'h0800;
      boot_reset_fuse <= 1;
      irq_event <= 8'h02;
      go;
      q.push_back(16'h0804);
      take;
      chk(16'h0800, reset_vector, "reset vector");
      ret;
      exec_cli <= 1;
      instr_done <= 1;
      go;
      go;
      chk(0, irq_busy, "entry after disable");
      status_register_wr <= 1;
      status_register_wdata <= 8'h80;
      app_lock_bit <= 1;
      go;
      instr_done <= 1;
      go;
      go;
      chk(0, irq_busy, "entry under lock");
      app_lock_bit <= 0;
      boot_lock_bit <= 1;
      q.push_back(16'h080c);
      take;
      ret;
      irq_en <= 8'h00;
      irq_level <= 8'h01;
      instr_done <= 1;
      go;
      irq_level <= 8'h00;
      irq_en <= 8'h01;
      instr_done <= 1;
      go;
      go;
      chk(0, irq_busy, "vanished level");
      irq_level <= 8'h01;
      sleeping <= 1;
      q.push_back(16'h0802);
      take;
      repeat (4) go;
      irq_level <= 8'h00;
      sleeping <= 0;
      irq_event <= 8'h80;
      go;
      flag_clr_wr <= 1;
      flag_clr_data <= 8'h80;
      go;
      chk(0, irq_flags, "software clear");
      chk(0, 17'(q.size()), "results outstanding");
      test_done;
   end
endmodule
